// ---- pkg/tick_pkg.sv ----
package tick_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
	localparam logic [ADDR_W-1:0] EVT_STATUS_OFFSET = 4'h1;
	localparam logic [ADDR_W-1:0] EVT_MASK_OFFSET = 4'h2;

	// tick_control_status field positions
	localparam int FLAG_BIT = 7;
	localparam int IRQ_EN_BIT = 6;
	localparam int RATE_HI = 5;
	localparam int RATE_LO = 4;
	localparam int ACK_BIT = 3;
	localparam int RUN_BIT = 2;
	localparam int XTAL_HI = 1;
	localparam int XTAL_LO = 0;

	// event status / mask field positions
	localparam int EVT_TICK_BIT = 0;

	// reset values
	localparam logic [1:0] XTAL_RESET = 2'h0;
	localparam logic [1:0] RATE_RESET = 2'h0;
	localparam logic EVT_MASK_RESET = 1'b0;

	// divider ratio n per crystal select
	localparam logic [7:0] RATIO_SEL0 = 8'h96;
	localparam logic [7:0] RATIO_SEL1 = 8'h7D;
	localparam logic [7:0] RATIO_SEL2 = 8'h80;
	localparam logic [7:0] RATIO_SEL3 = 8'h96;

	// chain stages above the n prescaler; tap for 1 Hz is the top stage
	localparam int CHAIN_W = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : tick_pkg

// ---- rtl/periodic_tick_unit.sv ----
`timescale 1ns/1ps
`default_nettype none

module periodic_tick_unit (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// crystal clock pin, asynchronous to mclk
	input wire logic crystal_clock,
	// low-power mode levels from the system
	input wire logic wait_mode,
	input wire logic stop_mode,
	// register port
	input wire tick_pkg::reg_req_t req,
	output logic [tick_pkg::DATA_W-1:0] rdata,
	// interrupt
	output logic irq
);

	function automatic logic [7:0] ratio_of(input logic [1:0] sel);
		case (sel)
			2'h0: ratio_of = tick_pkg::RATIO_SEL0;
			2'h1: ratio_of = tick_pkg::RATIO_SEL1;
			2'h2: ratio_of = tick_pkg::RATIO_SEL2;
			default: ratio_of = tick_pkg::RATIO_SEL3;
		endcase
	endfunction : ratio_of

	logic xclk_meta_reg;
	logic xclk_sync_reg;
	logic xclk_prev_reg;
	logic xclk_edge;
	logic [7:0] pre_reg;
	logic [tick_pkg::CHAIN_W-1:0] chain_reg;
	logic [tick_pkg::CHAIN_W-1:0] chain_next;
	logic pre_wrap;
	logic advance;
	logic tap_old;
	logic tap_new;
	logic tick;
	logic run_reg;
	logic irq_en_reg;
	logic [1:0] rate_reg;
	logic [1:0] xtal_reg;
	logic xtal_locked_reg;
	logic flag_reg;
	logic evt_status_reg;
	logic evt_mask_reg;
	logic [tick_pkg::DATA_W-1:0] rdata_reg;
	logic bus_ok;
	logic wr_ctrl;
	logic rd_status;
	logic ack_wr;
	logic [2:0] tap_idx;

	// two stages before any logic looks at the crystal clock
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			xclk_meta_reg <= 1'b0;
			xclk_sync_reg <= 1'b0;
			xclk_prev_reg <= 1'b0;
		end else begin
			xclk_meta_reg <= crystal_clock;
			xclk_sync_reg <= xclk_meta_reg;
			xclk_prev_reg <= xclk_sync_reg;
		end
	end

	assign xclk_edge = xclk_sync_reg & ~xclk_prev_reg;

	// stop freezes the chain; mclk itself keeps running here
	assign advance = run_reg & ~stop_mode & xclk_edge;
	assign pre_wrap = (pre_reg == ratio_of(xtal_reg) - 8'h01);
	assign chain_next = chain_reg + {{(tick_pkg::CHAIN_W-1){1'b0}}, 1'b1};
	// tap 7 for 1 Hz down to 4 for 8 Hz
	assign tap_idx = 3'h7 - {1'b0, rate_reg};
	assign tap_old = chain_reg[tap_idx];
	assign tap_new = chain_next[tap_idx];
	// rising tap edge: first after half the period from zero, then every period
	assign tick = advance & pre_wrap & ~tap_old & tap_new;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pre_reg <= 8'h00;
			chain_reg <= '0;
		end else if (!run_reg) begin
			pre_reg <= 8'h00;
			chain_reg <= '0;
		end else if (advance) begin
			if (pre_wrap) begin
				pre_reg <= 8'h00;
				chain_reg <= chain_next;
			end else begin
				pre_reg <= pre_reg + 8'h01;
			end
		end
	end

	// register access is shut off in wait mode
	assign bus_ok = ~wait_mode & ~stop_mode;
	assign wr_ctrl = bus_ok & req.wr & (req.addr == tick_pkg::CTRL_OFFSET);
	assign ack_wr = wr_ctrl & req.wdata[tick_pkg::ACK_BIT];
	assign rd_status = bus_ok & req.rd & (req.addr == tick_pkg::EVT_STATUS_OFFSET);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			run_reg <= 1'b0;
			irq_en_reg <= 1'b0;
			rate_reg <= tick_pkg::RATE_RESET;
		end else if (wr_ctrl) begin
			run_reg <= req.wdata[tick_pkg::RUN_BIT];
			irq_en_reg <= req.wdata[tick_pkg::IRQ_EN_BIT];
			rate_reg <= req.wdata[tick_pkg::RATE_HI:tick_pkg::RATE_LO];
		end
	end

	// any control write counts as the one crystal select write
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			xtal_reg <= tick_pkg::XTAL_RESET;
			xtal_locked_reg <= 1'b0;
		end else if (wr_ctrl && !xtal_locked_reg) begin
			xtal_reg <= req.wdata[tick_pkg::XTAL_HI:tick_pkg::XTAL_LO];
			xtal_locked_reg <= 1'b1;
		end
	end

	// set wins over acknowledge
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			flag_reg <= 1'b0;
		end else if (tick) begin
			flag_reg <= 1'b1;
		end else if (ack_wr) begin
			flag_reg <= 1'b0;
		end
	end

	// sticky event copy, cleared by reading it; set wins
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			evt_status_reg <= 1'b0;
		end else if (tick) begin
			evt_status_reg <= 1'b1;
		end else if (rd_status) begin
			evt_status_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			evt_mask_reg <= tick_pkg::EVT_MASK_RESET;
		end else if (bus_ok && req.wr && req.addr == tick_pkg::EVT_MASK_OFFSET) begin
			evt_mask_reg <= req.wdata[tick_pkg::EVT_TICK_BIT];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else if (bus_ok && req.rd) begin
			case (req.addr)
				tick_pkg::CTRL_OFFSET: begin
					// acknowledge position always reads zero
					rdata_reg <= {flag_reg, irq_en_reg, rate_reg, 1'b0, run_reg, xtal_reg};
				end
				tick_pkg::EVT_STATUS_OFFSET: begin
					rdata_reg <= {7'h00, evt_status_reg};
				end
				tick_pkg::EVT_MASK_OFFSET: begin
					rdata_reg <= {7'h00, evt_mask_reg};
				end
				default: begin
					rdata_reg <= 8'h00;
				end
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign rdata = rdata_reg;
	assign irq = (flag_reg & irq_en_reg) | (evt_status_reg & evt_mask_reg);

endmodule : periodic_tick_unit

`default_nettype wire

// ---- sim/tick_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module tick_sva (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// watched ports
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire tick_pkg::reg_req_t req,
	input wire logic [tick_pkg::DATA_W-1:0] rdata,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	wire logic ok = !wait_mode && !stop_mode;
	a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("rdata not idle");
	a_refused_zero: assert property ($past(req.rd && !ok) |-> rdata == 8'h00)
		else $error("refused read returned data");
	a_ack_reads_zero: assert property ($past(req.rd && req.addr == 4'h0) |-> !rdata[3])
		else $error("ack bit read one");
	a_unmapped_zero: assert property ($past(req.rd && req.addr > 4'h2) |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_irq_from_flag: assert property ($past(req.rd && ok && req.addr == 4'h0) && rdata[7]
		&& rdata[6] |-> $past(irq))
		else $error("flag and enable without irq");
	a_reset_quiet: assert property ($fell(reset) |-> !irq && rdata == 8'h00)
		else $error("outputs busy after reset");
	a_stop_holds: assert property (stop_mode [*4] |-> $stable(irq))
		else $error("irq moved in stop");
	a_wr_readback: assert property (req.wr && ok && req.addr == 4'h0 ##1 req.rd && ok
		&& req.addr == 4'h0 |=> rdata[6:4] == $past(req.wdata[6:4], 2))
		else $error("control readback wrong");
	c_tick: cover property (irq);
	c_wait_rd: cover property (req.rd && wait_mode);
	c_stop: cover property (stop_mode [*4]);
endmodule : tick_sva
bind periodic_tick_unit tick_sva u_tick_sva (.mclk(mclk), .reset(reset), .wait_mode(wait_mode),
	.stop_mode(stop_mode), .req(req), .rdata(rdata), .irq(irq));
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk = 0, reset = 1, crystal_clock = 0, wait_mode = 0, stop_mode = 0, irq, rd_q = 0;
	tick_pkg::reg_req_t req = '0;
	logic [7:0] rdata;
	logic [3:0] ua;
	logic [7:0] rq[$];
	int tq[$];
	int n_errors = 0, checks_done = 0, n_edge = 0, cyc = 0;
	periodic_tick_unit u_periodic_tick_unit (.mclk(mclk), .reset(reset),
		.crystal_clock(crystal_clock), .wait_mode(wait_mode), .stop_mode(stop_mode),
		.req(req), .rdata(rdata), .irq(irq));
	always #2 mclk = ~mclk;
	// crystal at mclk/8, well under the mclk/4 limit of the sync stage
	always #16 crystal_clock = ~crystal_clock;
	always @(posedge crystal_clock) n_edge++;
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp8
	task automatic cmp_cnt(input int g, input int e);
		checks_done++;
		if (g != e) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp_cnt
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{a, d, 1'b1, 1'b0};
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		rq.push_back(e);
	endtask : rd
	// strobes are one cycle long: drop them before any wait
	task automatic idle;
		@(posedge mclk);
		req <= '0;
	endtask : idle
	always @(posedge mclk) begin
		cyc++;
		if (rd_q)
			cmp8(rdata, rq.pop_front());
		rd_q <= req.rd;
		if (cyc > 70000) begin
			n_errors++;
			test_done();
		end
	end
	// tick moments counted in crystal edges since enable
	always @(posedge irq) if (!reset) cmp_cnt(n_edge, tq.pop_front());
	initial begin
		void'($urandom(46093));
		ua = 4'(3 + $urandom % 13);
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		rd(4'h0, 8'h00);
		rd(4'h2, 8'h00);
		wr(ua, 8'($urandom));
		rd(ua, 8'h00);
		wr(4'h0, 8'h31);
		idle();
		$display("reset test done");
		// enable between crystal rises so the edge count lines up
		@(negedge crystal_clock);
		wr(4'h0, 8'h74);
		n_edge = 0;
		tq.push_back(2000);
		tq.push_back(6000);
		rd(4'h0, 8'h75);
		wr(4'h2, 8'h00);
		idle();
		wait (irq === 1'b1);
		rd(4'h0, 8'hF5);
		wr(4'h0, 8'h7C);
		rd(4'h0, 8'h75);
		rd(4'h1, 8'h01);
		rd(4'h1, 8'h00);
		idle();
		wait_mode <= 1'b1;
		wr(4'h0, 8'h00);
		rd(4'h0, 8'h00);
		wr(4'h3, 8'h00);
		wait_mode <= 1'b0;
		rd(4'h0, 8'h75);
		idle();
		$display("first tick test done");
		wait (irq === 1'b1);
		stop_mode <= 1'b1;
		repeat (40) @(posedge mclk);
		stop_mode <= 1'b0;
		rd(4'h0, 8'hF5);
		idle();
		repeat (3) @(posedge mclk);
		$display("second tick test done");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
